// ### hdl/eee_mmd_regs.sv
// indirect device register bank for energy saving and time sync
`timescale 1ns/1ps
`include "eee_consts.svh"

module eee_mmd_regs (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        soft_reset,
   input  wire logic        mgmt_wr,
   input  wire logic        mgmt_rd,
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic [15:0] mgmt_wdata,
   input  wire logic        link_up,
   input  wire logic        wake_fault,
   input  wire logic        an_complete,
   input  wire logic [15:0] partner_page,
   output logic      [15:0] mgmt_rdata,
   output logic             mgmt_rvalid,
   output logic      [15:0] local_adv_page
);

   // reset image of the whole state
   localparam eee_pkg::eee_state_s ST_RST = '{
      func:     `EEE_FN_ADDR,
      devad:    5'h00,
      addr:     16'h0000,
      adv:      `EEE_ADV_RST,
      lp:       `EEE_LP_RST,
      wake_cnt: `EEE_CNT_RST,
      rdata:    16'h0000,
      rvalid:   1'b0
   };

   eee_pkg::eee_state_s st;
   eee_pkg::eee_state_s next_st;
   logic [15:0]         mmd_val;
   logic                cnt_clr;
   logic                addr_inc;

   // time sync capability word, transmit bit 1, receive bit 0
   function automatic logic [15:0] ts_cap(input logic [1:0] c);
      ts_cap = {14'h0000, c};
   endfunction : ts_cap

   // energy capability word of the pcs
   function automatic logic [15:0] energy_cap();
      logic [15:0] v;
      v = 16'h0000;
      v[`EEE_BIT_1000] = `EEE_CAP_1000;
      v[`EEE_BIT_100] = `EEE_CAP_100;
      energy_cap = v;
   endfunction : energy_cap

   // pma/pmd time sync registers
   function automatic logic [15:0] pma_reg(input logic [15:0] a);
      case (a)
         `EEE_A_TS_CAP: pma_reg = ts_cap(`EEE_PMA_TS_CAP);
         `EEE_A_TX_MAX: pma_reg = `EEE_PMA_TX_MAX;
         `EEE_A_TX_MIN: pma_reg = `EEE_PMA_TX_MIN;
         `EEE_A_RX_MAX: pma_reg = `EEE_PMA_RX_MAX;
         `EEE_A_RX_MIN: pma_reg = `EEE_PMA_RX_MIN;
         default:       pma_reg = 16'h0000;
      endcase
   endfunction : pma_reg

   // pcs time sync registers, delays split low then high
   function automatic logic [15:0] pcs_reg(input logic [15:0] a);
      case (a)
         `EEE_A_TS_CAP:    pcs_reg = ts_cap(`EEE_PCS_TS_CAP);
         `EEE_A_TX_MAX:    pcs_reg = `EEE_PCS_TX_MAX_LO;
         `EEE_A_TX_MAX_HI: pcs_reg = `EEE_PCS_TX_MAX_HI;
         `EEE_A_TX_MIN:    pcs_reg = `EEE_PCS_TX_MIN_LO;
         `EEE_A_TX_MIN_HI: pcs_reg = `EEE_PCS_TX_MIN_HI;
         `EEE_A_RX_MAX:    pcs_reg = `EEE_PCS_RX_MAX_LO;
         `EEE_A_RX_MAX_HI: pcs_reg = `EEE_PCS_RX_MAX_HI;
         `EEE_A_RX_MIN:    pcs_reg = `EEE_PCS_RX_MIN_LO;
         `EEE_A_RX_MIN_HI: pcs_reg = `EEE_PCS_RX_MIN_HI;
         default:          pcs_reg = 16'h0000;
      endcase
   endfunction : pcs_reg

   // mac side extender layer time sync registers
   function automatic logic [15:0] xs_reg(input logic [15:0] a);
      case (a)
         `EEE_A_TS_CAP: xs_reg = ts_cap(`EEE_XS_TS_CAP);
         `EEE_A_TX_MAX: xs_reg = `EEE_XS_TX_MAX;
         `EEE_A_TX_MIN: xs_reg = `EEE_XS_TX_MIN;
         `EEE_A_RX_MAX: xs_reg = `EEE_XS_RX_MAX;
         `EEE_A_RX_MIN: xs_reg = `EEE_XS_RX_MIN;
         default:       xs_reg = 16'h0000;
      endcase
   endfunction : xs_reg

   // true when device and address select the wake fault counter
   function automatic logic is_wake(input logic [4:0]  dev,
                                    input logic [15:0] a);
      is_wake = (dev == `EEE_DEV_PCS) && (a == `EEE_A_WAKE_CNT);
   endfunction : is_wake

   // read value of one device register
   function automatic logic [15:0] mmd_read(
      input logic [4:0]  dev,
      input logic [15:0] a,
      input logic [15:0] adv,
      input logic [15:0] lp,
      input logic [15:0] cnt,
      input logic        link
   );
      logic [15:0] v;
      v = 16'h0000;
      case (dev)
         `EEE_DEV_PMA: begin
            if (link) begin
               v = pma_reg(a);
            end
         end
         `EEE_DEV_PCS: begin
            if (a == `EEE_A_ENERGY_CAP) begin
               v = energy_cap();
            end else if (is_wake(dev, a)) begin
               v = cnt;
            end else if (link) begin
               v = pcs_reg(a);
            end
         end
         `EEE_DEV_XS: begin
            if (link) begin
               v = xs_reg(a);
            end
         end
         `EEE_DEV_AN: begin
            if (a == `EEE_A_LOCAL_ADV) begin
               v = adv;
            end else if (a == `EEE_A_PARTNER_ADV) begin
               v = lp;
            end
         end
         default: begin
            v = 16'h0000;
         end
      endcase
      mmd_read = v;
   endfunction : mmd_read

   // value of the currently selected device register
   assign mmd_val = mmd_read(st.devad, st.addr, st.adv, st.lp,
                             st.wake_cnt, link_up);

   // next state: management access, counter, partner load
   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      cnt_clr = 1'b0;
      addr_inc = 1'b0;
      // management writes take precedence over reads
      if (mgmt_wr) begin
         case (mgmt_addr)
            `EEE_REG_MMD_CTRL: begin
               next_st.func = mgmt_wdata[15:14];
               next_st.devad = mgmt_wdata[4:0];
            end
            `EEE_REG_MMD_DATA: begin
               if (st.func == `EEE_FN_ADDR) begin
                  next_st.addr = mgmt_wdata;
               end else begin
                  addr_inc = (st.func != `EEE_FN_DATA);
                  // only the local advertisement is writable
                  if ((st.devad == `EEE_DEV_AN) &&
                      (st.addr == `EEE_A_LOCAL_ADV)) begin
                     next_st.adv = mgmt_wdata & `EEE_ADV_MASK;
                  end
               end
            end
            default: begin
               next_st.func = st.func;
            end
         endcase
      end else if (mgmt_rd) begin
         next_st.rvalid = 1'b1;
         case (mgmt_addr)
            `EEE_REG_MMD_CTRL: begin
               next_st.rdata = {st.func, 9'h000, st.devad};
            end
            `EEE_REG_MMD_DATA: begin
               if (st.func == `EEE_FN_ADDR) begin
                  next_st.rdata = st.addr;
               end else begin
                  next_st.rdata = mmd_val;
                  cnt_clr = is_wake(st.devad, st.addr);
                  addr_inc = (st.func == `EEE_FN_INC_RW);
               end
            end
            default: begin
               next_st.rdata = 16'h0000;
            end
         endcase
      end
      // post increment of the register address
      if (addr_inc) begin
         next_st.addr = st.addr + 16'h0001;
      end
      // wake fault counting; a fault in the clearing cycle is kept
      if (wake_fault) begin
         if (cnt_clr) begin
            next_st.wake_cnt = 16'h0001;
         end else if (st.wake_cnt != `EEE_CNT_MAX) begin
            next_st.wake_cnt = st.wake_cnt + 16'h0001;
         end
      end else if (cnt_clr) begin
         next_st.wake_cnt = `EEE_CNT_RST;
      end
      // partner advertisement captured at negotiation end
      if (an_complete) begin
         next_st.lp = partner_page & `EEE_ADV_MASK;
      end
      // software reset returns every register to reset value
      if (soft_reset) begin
         next_st = ST_RST;
      end
   end

   // state register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state flops
   assign mgmt_rdata = st.rdata;
   assign mgmt_rvalid = st.rvalid;
   assign local_adv_page = st.adv;

endmodule : eee_mmd_regs

// ### pkg/eee_consts.svh
// constants for the energy efficient and time sync management registers
// Behaviour
// - energy capability bit 2 reads 1 when 1000BASE-T energy saving is supported, read-only.
// - energy capability bit 1 reads 1 when 100BASE-TX energy saving is supported; bits 0 and 15:3 read zero.
// - each wake sequence that misses its deadline, in refresh or wakeup, adds one to the wake fault counter; the code holds the count at 16'hffff.
// - the 16-bit wake fault counter clears when read and on hardware or software reset.
// - the local advertisement is what goes out in the next page after the energy technology message.
// - advertisement bit 2 is writable, resets to 0, and enables the 1000BASE-T energy advertisement.
// - advertisement bit 1 is writable, resets to 0, and enables the 100BASE-TX energy advertisement.
// - the partner advertisement register is read-only and writes leave it unchanged.
// - on auto-negotiation complete the partner register loads bit 2 and bit 1 from the remote page.
// - while the link is down every time sync capability and delay register reads zero.
// - each register is selected by device address and register address, such as 1.1801.
// - each layer's time sync capability shows transmit in bit 1 and receive in bit 0.
// - PCS path delays are split into a low register and the following high register.
// - the PMA/PMD delay registers give transmit and receive maximum and minimum delay.
// - the MAC side extender layer delay registers give transmit and receive maximum and minimum delay.
`ifndef EEE_CONSTS_SVH
`define EEE_CONSTS_SVH
`define EEE_REG_MMD_CTRL   5'h0d
`define EEE_REG_MMD_DATA   5'h0e
`define EEE_DEV_PMA        5'h01
`define EEE_DEV_PCS        5'h03
`define EEE_DEV_XS         5'h04
`define EEE_DEV_AN         5'h07
`define EEE_A_TS_CAP       16'h0708
`define EEE_A_TX_MAX       16'h0709
`define EEE_A_TX_MAX_HI    16'h070a
`define EEE_A_TX_MIN       16'h070b
`define EEE_A_TX_MIN_HI    16'h070c
`define EEE_A_RX_MAX       16'h070d
`define EEE_A_RX_MAX_HI    16'h070e
`define EEE_A_RX_MIN       16'h070f
`define EEE_A_RX_MIN_HI    16'h0710
`define EEE_A_ENERGY_CAP   16'h0014
`define EEE_A_WAKE_CNT     16'h0016
`define EEE_A_LOCAL_ADV    16'h003c
`define EEE_A_PARTNER_ADV  16'h003d
`define EEE_BIT_1000       2
`define EEE_BIT_100        1
`define EEE_FN_ADDR        2'h0
`define EEE_FN_DATA        2'h1
`define EEE_FN_INC_RW      2'h2
`define EEE_FN_INC_WR      2'h3
`define EEE_ADV_MASK       16'h0006
`define EEE_ADV_RST        16'h0000
`define EEE_LP_RST         16'h0000
`define EEE_CNT_RST        16'h0000
`define EEE_CNT_MAX        16'hffff
`define EEE_CAP_1000       1'b1
`define EEE_CAP_100        1'b1
`define EEE_PMA_TS_CAP     2'h3
`define EEE_PCS_TS_CAP     2'h3
`define EEE_XS_TS_CAP      2'h3
`define EEE_PMA_TX_MAX     16'h0040
`define EEE_PMA_TX_MIN     16'h0030
`define EEE_PMA_RX_MAX     16'h0050
`define EEE_PMA_RX_MIN     16'h0038
`define EEE_PCS_TX_MAX_LO  16'h0120
`define EEE_PCS_TX_MAX_HI  16'h0000
`define EEE_PCS_TX_MIN_LO  16'h0100
`define EEE_PCS_TX_MIN_HI  16'h0000
`define EEE_PCS_RX_MAX_LO  16'h0140
`define EEE_PCS_RX_MAX_HI  16'h0000
`define EEE_PCS_RX_MIN_LO  16'h0110
`define EEE_PCS_RX_MIN_HI  16'h0000
`define EEE_XS_TX_MAX      16'h0020
`define EEE_XS_TX_MIN      16'h0010
`define EEE_XS_RX_MAX      16'h0024
`define EEE_XS_RX_MIN      16'h0014
`endif

// ### pkg/eee_pkg.sv
// types for the energy efficient and time sync management registers
package eee_pkg;

   // whole state of the register block
   typedef struct packed {
      logic [1:0]  func;     // access control function
      logic [4:0]  devad;    // selected device address
      logic [15:0] addr;     // selected register address
      logic [15:0] adv;      // local energy advertisement
      logic [15:0] lp;       // partner energy advertisement
      logic [15:0] wake_cnt; // wake fault count
      logic [15:0] rdata;    // last read answer
      logic        rvalid;   // read answer strobe
   } eee_state_s;

endpackage : eee_pkg

// ### tb/eee_mmd_checker.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`include "eee_consts.svh"
module eee_mmd_checker (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        soft_reset,
   input wire logic        mgmt_wr,
   input wire logic        mgmt_rd,
   input wire logic [4:0]  mgmt_addr,
   input wire logic [15:0] mgmt_wdata,
   input wire logic        link_up,
   input wire logic        wake_fault,
   input wire logic        an_complete,
   input wire logic [15:0] partner_page,
   input wire logic [15:0] mgmt_rdata,
   input wire logic        mgmt_rvalid,
   input wire logic [15:0] local_adv_page
);
   // one clock domain for every check
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   AST_RD_ANSWER: assert property (
      mgmt_rd && !mgmt_wr && !soft_reset |=> mgmt_rvalid)
      else $error("read got no answer strobe");
   AST_NO_ANSWER: assert property (
      !(mgmt_rd && !mgmt_wr) || soft_reset |=> !mgmt_rvalid)
      else $error("answer strobe without read");
   AST_ADV_RSVD: assert property (
      local_adv_page[15:3] == 13'h0000 && !local_adv_page[0])
      else $error("reserved advertisement bit set");
   AST_SOFT_RESET: assert property (
      soft_reset |=> local_adv_page == 16'h0000 && !mgmt_rvalid)
      else $error("soft reset left state");
   AST_RDATA_HOLD: assert property (
      !mgmt_rvalid && !$past(soft_reset) |-> $stable(mgmt_rdata))
      else $error("read data moved without answer");
   AST_ADV_CAUSE: assert property (
      !$stable(local_adv_page) |-> $past(mgmt_wr) || $past(soft_reset))
      else $error("advertisement moved without write");
   AST_UNMAPPED: assert property (
      mgmt_rd && !mgmt_wr && !soft_reset
      && mgmt_addr != `EEE_REG_MMD_CTRL && mgmt_addr != `EEE_REG_MMD_DATA
      |=> mgmt_rdata == 16'h0000)
      else $error("unmapped register read not zero");
   AST_EVENT_NO_ADV: assert property (
      (an_complete || wake_fault) && !mgmt_wr && !soft_reset
      |=> $stable(local_adv_page))
      else $error("event changed advertisement");
endmodule : eee_mmd_checker

bind eee_mmd_regs eee_mmd_checker u_chk (.mclk, .resetn, .soft_reset,
   .mgmt_wr, .mgmt_rd, .mgmt_addr, .mgmt_wdata, .link_up, .wake_fault,
   .an_complete, .partner_page, .mgmt_rdata, .mgmt_rvalid, .local_adv_page);

// ### tb/eee_sta_model.sv
// station management model doing indirect device accesses
`timescale 1ns/1ps
`include "eee_consts.svh"
module eee_sta_model (
   input  wire logic        mclk,
   output logic             mgmt_wr,
   output logic             mgmt_rd,
   output logic      [4:0]  mgmt_addr,
   output logic      [15:0] mgmt_wdata,
   input  wire logic [15:0] mgmt_rdata,
   input  wire logic        mgmt_rvalid
);
   // idle bus at time zero
   initial begin
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      mgmt_addr = 5'h00;
      mgmt_wdata = 16'h0000;
   end
   // one write strobe, lines inverted once released
   task automatic c22_wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk);
      mgmt_wr    <= 1'b1;
      mgmt_addr  <= a;
      mgmt_wdata <= d;
      @(posedge mclk);
      mgmt_wr    <= 1'b0;
      mgmt_addr  <= ~a;
      mgmt_wdata <= ~d;
   endtask : c22_wr
   // one read strobe, bounded wait for the answer
   task automatic c22_rd(input logic [4:0] a, output logic [15:0] d);
      d = 16'hxxxx;
      @(posedge mclk);
      mgmt_rd   <= 1'b1;
      mgmt_addr <= a;
      @(posedge mclk);
      mgmt_rd   <= 1'b0;
      mgmt_addr <= ~a;
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         if (mgmt_rvalid === 1'b1) begin
            d = mgmt_rdata;
            break;
         end
      end
   endtask : c22_rd
   // select device, register and access function through 13 and 14
   task automatic mmd_mode(input logic [4:0]  dev,
                           input logic [15:0] a,
                           input logic [1:0]  fn);
      c22_wr(`EEE_REG_MMD_CTRL, {`EEE_FN_ADDR, 9'h000, dev});
      c22_wr(`EEE_REG_MMD_DATA, a);
      c22_wr(`EEE_REG_MMD_CTRL, {fn, 9'h000, dev});
   endtask : mmd_mode
   // select device and register for plain data access
   task automatic mmd_sel(input logic [4:0] dev, input logic [15:0] a);
      mmd_mode(dev, a, `EEE_FN_DATA);
   endtask : mmd_sel
   task automatic mmd_wr(input logic [4:0] dev, input logic [15:0] a,
                         input logic [15:0] d);
      mmd_sel(dev, a);
      c22_wr(`EEE_REG_MMD_DATA, d);
   endtask : mmd_wr
   task automatic mmd_rd(input logic [4:0] dev, input logic [15:0] a,
                         output logic [15:0] d);
      mmd_sel(dev, a);
      c22_rd(`EEE_REG_MMD_DATA, d);
   endtask : mmd_rd
endmodule : eee_sta_model

// ### tb/eee_mmd_regs_bench.sv
// self-checking bench for the energy and time sync register bank
`timescale 1ns/1ps
`include "eee_consts.svh"
module eee_mmd_regs_bench;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        soft_reset = 1'b0;
   logic        link_up = 1'b1;
   logic        wake_fault = 1'b0;
   logic        an_complete = 1'b0;
   logic [15:0] partner_page = 16'h0000;
   logic        mgmt_wr;
   logic        mgmt_rd;
   logic [4:0]  mgmt_addr;
   logic [15:0] mgmt_wdata;
   logic [15:0] mgmt_rdata;
   logic        mgmt_rvalid;
   logic [15:0] local_adv_page;
   logic [15:0] v;
   int          error_cnt = 0;
   int          tests_run = 0;
   eee_mmd_regs u_dut (.mclk, .resetn, .soft_reset, .mgmt_wr, .mgmt_rd,
      .mgmt_addr, .mgmt_wdata, .link_up, .wake_fault, .an_complete,
      .partner_page, .mgmt_rdata, .mgmt_rvalid, .local_adv_page);
   eee_sta_model u_sta (.mclk, .mgmt_wr, .mgmt_rd, .mgmt_addr, .mgmt_wdata,
      .mgmt_rdata, .mgmt_rvalid);
   // 250 MHz clock
   initial begin
      forever #2 mclk = ~mclk;
   end
   task automatic finish_test;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // indirect read then compare
   task automatic rc(input logic [4:0] d, input logic [15:0] a,
                     input logic [15:0] exp);
      logic [15:0] r;
      u_sta.mmd_rd(d, a, r);
      chk(r, exp);
   endtask : rc
   task automatic t_caps;
      u_sta.c22_rd(5'h00, v);
      chk(v, 16'h0000);
      rc(5'h03, 16'd20, 16'h0006);
      u_sta.mmd_wr(5'h03, 16'd20, 16'h0000);
      rc(5'h03, 16'd20, 16'h0006);
      rc(5'h01, 16'd1800, 16'h0003);
      rc(5'h03, 16'd1800, 16'h0003);
      rc(5'h04, 16'd1800, 16'h0003);
      rc(5'h01, 16'd1801, 16'h0040);
      rc(5'h01, 16'd1807, 16'h0038);
      rc(5'h03, 16'd1801, 16'h0120);
      rc(5'h03, 16'd1802, 16'h0000);
      rc(5'h03, 16'd1807, 16'h0110);
      rc(5'h04, 16'd1805, 16'h0024);
      rc(5'h03, 16'd1809, 16'h0000);
   endtask : t_caps
   task automatic t_link_down;
      link_up <= 1'b0;
      rc(5'h01, 16'd1801, 16'h0000);
      rc(5'h03, 16'd1808, 16'h0000);
      rc(5'h04, 16'd1800, 16'h0000);
      rc(5'h03, 16'd20, 16'h0006);
      link_up <= 1'b1;
   endtask : t_link_down
   task automatic t_adv;
      rc(5'h07, 16'd60, 16'h0000);
      u_sta.mmd_wr(5'h07, 16'd60, 16'hffff);
      rc(5'h07, 16'd60, 16'h0006);
      chk(local_adv_page, 16'h0006);
      u_sta.mmd_wr(5'h07, 16'd60, 16'h0002);
      rc(5'h07, 16'd60, 16'h0002);
      chk(local_adv_page, 16'h0002);
      u_sta.mmd_wr(5'h07, 16'd60, 16'h0004);
      rc(5'h07, 16'd60, 16'h0004);
   endtask : t_adv
   task automatic ev_an(input logic [15:0] p);
      @(posedge mclk);
      an_complete  <= 1'b1;
      partner_page <= p;
      @(posedge mclk);
      an_complete  <= 1'b0;
      partner_page <= ~p;
   endtask : ev_an
   task automatic t_partner;
      ev_an(16'hffff);
      rc(5'h07, 16'd61, 16'h0006);
      u_sta.mmd_wr(5'h07, 16'd61, 16'h0000);
      rc(5'h07, 16'd61, 16'h0006);
      ev_an(16'h0002);
      rc(5'h07, 16'd61, 16'h0002);
   endtask : t_partner
   task automatic t_wake;
      repeat (3) @(posedge mclk) wake_fault <= 1'b1;
      @(posedge mclk) wake_fault <= 1'b0;
      rc(5'h03, 16'd22, 16'h0003);
      rc(5'h03, 16'd22, 16'h0000);
      repeat (2) @(posedge mclk) wake_fault <= 1'b1;
      @(posedge mclk) wake_fault <= 1'b0;
      @(posedge mclk) soft_reset <= 1'b1;
      @(posedge mclk) soft_reset <= 1'b0;
      rc(5'h03, 16'd22, 16'h0000);
      rc(5'h07, 16'd60, 16'h0000);
   endtask : t_wake
   // post increment on read and write, control and address read back
   task automatic t_incr;
      u_sta.mmd_mode(5'h03, 16'd1801, `EEE_FN_INC_RW);
      u_sta.c22_rd(5'h0e, v);
      chk(v, 16'h0120);
      u_sta.c22_rd(5'h0e, v);
      chk(v, 16'h0000);
      u_sta.c22_rd(5'h0e, v);
      chk(v, 16'h0100);
      u_sta.c22_rd(5'h0d, v);
      chk(v, 16'h8003);
      u_sta.mmd_mode(5'h07, 16'd60, `EEE_FN_INC_WR);
      u_sta.c22_wr(5'h0e, 16'h0006);
      u_sta.c22_rd(5'h0e, v);
      u_sta.c22_rd(5'h0e, v);
      chk(local_adv_page, 16'h0006);
      u_sta.c22_wr(5'h0d, 16'h0007);
      u_sta.c22_rd(5'h0e, v);
      chk(v, 16'h003d);
   endtask : t_incr
   // hardware reset in mid-run clears counter and advertisement
   task automatic t_hw_reset;
      repeat (2) @(posedge mclk) wake_fault <= 1'b1;
      @(posedge mclk) wake_fault <= 1'b0;
      u_sta.mmd_wr(5'h07, 16'd60, 16'h0006);
      @(posedge mclk) resetn <= 1'b0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      chk(local_adv_page, 16'h0000);
      rc(5'h03, 16'd22, 16'h0000);
      rc(5'h07, 16'd60, 16'h0000);
   endtask : t_hw_reset
   // wake fault in the clearing read cycle is kept
   task automatic t_clash;
      @(posedge mclk) wake_fault <= 1'b1;
      @(posedge mclk) wake_fault <= 1'b0;
      u_sta.mmd_sel(5'h03, 16'd22);
      fork
         u_sta.c22_rd(5'h0e, v);
         begin
            @(posedge mclk) wake_fault <= 1'b1;
            @(posedge mclk) wake_fault <= 1'b0;
         end
      join
      chk(v, 16'h0001);
      rc(5'h03, 16'd22, 16'h0001);
      rc(5'h03, 16'd22, 16'h0000);
   endtask : t_clash
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      t_caps();
      t_link_down();
      t_adv();
      t_partner();
      t_wake();
      t_incr();
      t_hw_reset();
      t_clash();
      finish_test();
   end
endmodule : eee_mmd_regs_bench
